/* rtl/gtu_pkg.sv */
// Shared constants for the dual module timer unit
package gtu_pkg;
    // Register word addresses
    localparam logic [3:0] GTU_ADR_LOWER_CTL = 4'h0;
    localparam logic [3:0] GTU_ADR_CORE_CTL = 4'h1;
    localparam logic [3:0] GTU_ADR_UPPER_CTL = 4'h2;
    localparam logic [3:0] GTU_ADR_A_CTL = 4'h3;
    localparam logic [3:0] GTU_ADR_B_CTL = 4'h4;
    localparam logic [3:0] GTU_ADR_CAP_CTL = 4'h5;
    localparam logic [3:0] GTU_ADR_LOWER_VAL = 4'h8;
    localparam logic [3:0] GTU_ADR_CORE_VAL = 4'h9;
    localparam logic [3:0] GTU_ADR_UPPER_VAL = 4'ha;
    localparam logic [3:0] GTU_ADR_A_VAL = 4'hb;
    localparam logic [3:0] GTU_ADR_B_VAL = 4'hc;
    localparam logic [3:0] GTU_ADR_CAPREG = 4'hd;
    localparam logic [3:0] GTU_ADR_STATUS = 4'he;
    // Timer control field positions
    localparam int GTU_F_MODE_LO = 0;
    localparam int GTU_F_PRE_LO = 3;
    localparam int GTU_F_RUN = 6;
    localparam int GTU_F_DOWN = 7;
    localparam int GTU_F_EXTDIR = 8;
    localparam int GTU_F_GATE_HI = 9;
    localparam int GTU_F_LATCH_CLK = 10;
    localparam int GTU_F_EDGE_LO = 11;
    localparam int GTU_F_TLSEL_LO = 13;
    // Capture control field positions
    localparam int GTU_C_EDGE_LO = 0;
    localparam int GTU_C_CLEAR = 2;
    localparam int GTU_C_CORE_IN = 3;
    localparam int GTU_C_CORE_DIR = 4;
    localparam int GTU_C_RELOAD_B = 5;
    // Reset values
    localparam logic [15:0] GTU_CTL_RST = 16'h0000;
    localparam logic [15:0] GTU_VAL_RST = 16'h0000;
    // Finest resolution in system clocks per count
    localparam int GTU_RES1_CYC = 4;
    localparam int GTU_RES2_CYC = 2;
    localparam int GTU_RES1_BITS = $clog2(GTU_RES1_CYC);
    localparam int GTU_RES2_BITS = $clog2(GTU_RES2_CYC);
    // Operating modes
    typedef enum logic [2:0] {
        GTU_MODE_TIMER = 3'b000,
        GTU_MODE_GATED = 3'b001,
        GTU_MODE_COUNT = 3'b010,
        GTU_MODE_INCR = 3'b011,
        GTU_MODE_RELOAD = 3'b100,
        GTU_MODE_CAPTURE = 3'b101
    } gtu_mode_t;
endpackage

/* rtl/gtu_timer_unit.sv */
// Five timer, two module timer/counter unit with register port
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Five 16-bit timers in two modules
// - First module timers: timer, gated, counter, incremental
// - Timer mode counts prescaled system clock
// - Counter mode counts pin edges
// - Gated mode counts only at gate level
// - First module: one count per four clocks
// - Direction by software or direction pin
// - Incremental mode tracks quadrature sensor position
// - Core latch toggles on wrap, clocks aux
// - Aux timers capture or reload, then stopped
// - Capture latches core on aux pin
// - Core reload on pin or latch edge
// - Opposite latch reloads give continuous PWM
// - Second module: two timers, register, two clocks
// - Second module prescaled/external; timer a pinless direction
// - Timer b latch clocks timer a, output
// - Timer b wrap pulses out, reloads b
// - Capture register latches timer a, optional clear
// - Capture also from core input pins
module gtu_timer_unit #(
    parameter int PRE_W = 12
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic lower_in,
    input wire logic core_count_input,
    input wire logic upper_in,
    input wire logic lower_dir_in,
    input wire logic core_direction_input,
    input wire logic upper_dir_in,
    input wire logic timer_a_in,
    input wire logic timer_b_in,
    input wire logic timer_b_dir_in,
    input wire logic capture_input_pin,
    output logic core_toggle_output,
    output logic second_toggle_output,
    output logic timer_b_overflow
);
    import gtu_pkg::*;

    // Clock prescale tick: low base+ps bits of free counter all ones
    function automatic logic pre_tick(input logic [PRE_W-1:0] cnt, input int base, input logic [2:0] ps);
        logic [PRE_W-1:0] m;
        m = PRE_W'((1 << (base + int'(ps))) - 1);
        return (cnt & m) == m;
    endfunction

    // Edge select: bit 0 rising, bit 1 falling
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        return (sel[0] & r) | (sel[1] & f);
    endfunction

    // One count step; top bit flags wrap
    function automatic logic [16:0] step(input logic [15:0] v, input logic up);
        logic [16:0] r;
        r = up ? {v == 16'hffff, 16'(v + 16'h0001)} : {v == 16'h0000, 16'(v - 16'h0001)};
        return r;
    endfunction

    // Pin vector: 0-2 timer inputs, 3-5 direction inputs, 6-9 module two
    logic [9:0] pins;
    logic [9:0] pin_p_q, pin_p_d; // Previous pin levels
    logic [9:0] rise, fall;
    assign pins = {capture_input_pin, timer_b_dir_in, timer_b_in, timer_a_in,
                   upper_dir_in, core_direction_input, lower_dir_in, upper_in, core_count_input, lower_in};

    // Pin history next value
    always_comb begin
        pin_p_d = pins;
        rise = pins & ~pin_p_q;
        fall = ~pins & pin_p_q;
    end

    // Pin history register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_p_q <= 10'h000;
        end else begin
            pin_p_q <= pin_p_d;
        end
    end

    // State: first module (0 lower, 1 core, 2 upper), second module, latches
    logic [15:0] ctl1_q [0:2], ctl1_d [0:2];
    logic [15:0] tmr_q [0:2], tmr_d [0:2];
    logic [15:0] ctla_q, ctla_d, ctlb_q, ctlb_d, capctl_q, capctl_d;
    logic [15:0] tma_q, tma_d, tmb_q, tmb_d, capture_reload_register_q, capture_reload_register_d;
    logic tl3_q, tl3_d, tl3_p_q, tl3_p_d, tl6_q, tl6_d, tl6_p_q, tl6_p_d;
    logic bovf_q, bovf_d;
    logic [PRE_W-1:0] pre_q, pre_d; // Free running prescale counter
    logic [15:0] rdata_q, rdata_d;

    // Decoded events, visible for checking
    logic [2:0] en1, up1, wrap1, cap_hit, rl_hit;
    logic [16:0] st1 [0:2];
    logic tl3_chg, tl6_chg, en_a, en_b, wrap_a, wrap_b, trig2;
    logic [16:0] st_a, st_b;
    gtu_mode_t mode1 [0:2];

    // Next state of whole unit
    always_comb begin
        logic src;
        logic [1:0] es;
        // Locals set first, reused per timer
        src = 1'b0;
        es = 2'b00;
        pre_d = PRE_W'(pre_q + 1'b1);
        tl3_p_d = tl3_q;
        tl6_p_d = tl6_q;
        tl3_chg = tl3_q ^ tl3_p_q;
        tl6_chg = tl6_q ^ tl6_p_q;
        // First module count enable and direction
        for (int i = 0; i < 3; i++) begin
            mode1[i] = gtu_mode_t'(ctl1_q[i][GTU_F_MODE_LO +: 3]);
            es = ctl1_q[i][GTU_F_EDGE_LO +: 2];
            // Aux may be clocked by core latch changes
            src = (i != 1 && ctl1_q[i][GTU_F_LATCH_CLK]) ? tl3_chg :
                  pre_tick(pre_q, GTU_RES1_BITS, ctl1_q[i][GTU_F_PRE_LO +: 3]);
            case (mode1[i])
                GTU_MODE_TIMER: en1[i] = src;
                GTU_MODE_GATED: en1[i] = src & (pins[i] == ctl1_q[i][GTU_F_GATE_HI]);
                GTU_MODE_COUNT: en1[i] = edge_hit(es, rise[i], fall[i]);
                GTU_MODE_INCR: en1[i] = rise[i] | fall[i] | rise[i+3] | fall[i+3];
                default: en1[i] = 1'b0;
            endcase
            en1[i] = en1[i] & ctl1_q[i][GTU_F_RUN] & (i == 1 || mode1[i] < GTU_MODE_RELOAD);
            // Quadrature: A leading B counts up
            up1[i] = (mode1[i] == GTU_MODE_INCR) ? (pins[i] ^ pin_p_q[i+3]) :
                     ~(ctl1_q[i][GTU_F_DOWN] ^ (ctl1_q[i][GTU_F_EXTDIR] & pins[i+3]));
            st1[i] = step(tmr_q[i], up1[i]);
            wrap1[i] = en1[i] & st1[i][16];
            cap_hit[i] = (i != 1) && mode1[i] == GTU_MODE_CAPTURE && edge_hit(es, rise[i], fall[i]);
            // Reload on pin edge or selected latch transition
            rl_hit[i] = (i != 1) && mode1[i] == GTU_MODE_RELOAD &&
                        (edge_hit(es, rise[i], fall[i]) ||
                         edge_hit(ctl1_q[i][GTU_F_TLSEL_LO +: 2], wrap1[1] & ~tl3_q, wrap1[1] & tl3_q));
        end
        // Core latch toggles on every wrap
        tl3_d = tl3_q ^ wrap1[1];
        for (int i = 0; i < 3; i++) begin
            ctl1_d[i] = ctl1_q[i];
            tmr_d[i] = en1[i] ? st1[i][15:0] : tmr_q[i];
        end
        if (rl_hit[0]) begin
            tmr_d[1] = tmr_q[0];
        end else if (rl_hit[2]) begin
            tmr_d[1] = tmr_q[2];
        end
        if (cap_hit[0]) begin
            tmr_d[0] = tmr_q[1];
        end
        if (cap_hit[2]) begin
            tmr_d[2] = tmr_q[1];
        end
        // Second module timer b: prescaled or pin edges, pin direction
        en_b = ctlb_q[GTU_F_RUN] & ((ctlb_q[GTU_F_MODE_LO +: 3] == GTU_MODE_COUNT) ?
               edge_hit(ctlb_q[GTU_F_EDGE_LO +: 2], rise[7], fall[7]) :
               pre_tick(pre_q, GTU_RES2_BITS, ctlb_q[GTU_F_PRE_LO +: 3]));
        st_b = step(tmb_q, ~(ctlb_q[GTU_F_DOWN] ^ (ctlb_q[GTU_F_EXTDIR] & pins[8])));
        wrap_b = en_b & st_b[16];
        // Timer a: prescaled, latch clocked, or pin; direction software only
        src = ctla_q[GTU_F_LATCH_CLK] ? tl6_chg : pre_tick(pre_q, GTU_RES2_BITS, ctla_q[GTU_F_PRE_LO +: 3]);
        en_a = ctla_q[GTU_F_RUN] & ((ctla_q[GTU_F_MODE_LO +: 3] == GTU_MODE_COUNT) ?
               edge_hit(ctla_q[GTU_F_EDGE_LO +: 2], rise[6], fall[6]) : src);
        st_a = step(tma_q, ~ctla_q[GTU_F_DOWN]);
        wrap_a = en_a & st_a[16];
        tl6_d = tl6_q ^ wrap_b;
        bovf_d = wrap_b;
        tmb_d = en_b ? st_b[15:0] : tmb_q;
        if (wrap_b && capctl_q[GTU_C_RELOAD_B]) begin
            tmb_d = capture_reload_register_q;
        end
        // Capture trigger from own pin or core inputs
        trig2 = edge_hit(capctl_q[GTU_C_EDGE_LO +: 2], rise[9], fall[9]) |
                (capctl_q[GTU_C_CORE_IN] & (rise[1] | fall[1])) |
                (capctl_q[GTU_C_CORE_DIR] & (rise[4] | fall[4]));
        capture_reload_register_d = trig2 ? tma_q : capture_reload_register_q;
        tma_d = (trig2 && capctl_q[GTU_C_CLEAR]) ? 16'h0000 : (en_a ? st_a[15:0] : tma_q);
        ctla_d = ctla_q;
        ctlb_d = ctlb_q;
        capctl_d = capctl_q;
        // Software writes win over hardware updates
        if (reg_wr) begin
            case (reg_addr)
                GTU_ADR_LOWER_CTL: ctl1_d[0] = reg_wdata;
                GTU_ADR_CORE_CTL: ctl1_d[1] = reg_wdata;
                GTU_ADR_UPPER_CTL: ctl1_d[2] = reg_wdata;
                GTU_ADR_A_CTL: ctla_d = reg_wdata;
                GTU_ADR_B_CTL: ctlb_d = reg_wdata;
                GTU_ADR_CAP_CTL: capctl_d = reg_wdata;
                GTU_ADR_LOWER_VAL: tmr_d[0] = reg_wdata;
                GTU_ADR_CORE_VAL: tmr_d[1] = reg_wdata;
                GTU_ADR_UPPER_VAL: tmr_d[2] = reg_wdata;
                GTU_ADR_A_VAL: tma_d = reg_wdata;
                GTU_ADR_B_VAL: tmb_d = reg_wdata;
                GTU_ADR_CAPREG: capture_reload_register_d = reg_wdata;
                default: ;
            endcase
        end
        // Read data for the following cycle
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                GTU_ADR_LOWER_CTL: rdata_d = ctl1_q[0];
                GTU_ADR_CORE_CTL: rdata_d = ctl1_q[1];
                GTU_ADR_UPPER_CTL: rdata_d = ctl1_q[2];
                GTU_ADR_A_CTL: rdata_d = ctla_q;
                GTU_ADR_B_CTL: rdata_d = ctlb_q;
                GTU_ADR_CAP_CTL: rdata_d = capctl_q;
                GTU_ADR_LOWER_VAL: rdata_d = tmr_q[0];
                GTU_ADR_CORE_VAL: rdata_d = tmr_q[1];
                GTU_ADR_UPPER_VAL: rdata_d = tmr_q[2];
                GTU_ADR_A_VAL: rdata_d = tma_q;
                GTU_ADR_B_VAL: rdata_d = tmb_q;
                GTU_ADR_CAPREG: rdata_d = capture_reload_register_q;
                GTU_ADR_STATUS: rdata_d = {14'h0000, tl6_q, tl3_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Register all unit state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                ctl1_q[i] <= GTU_CTL_RST;
                tmr_q[i] <= GTU_VAL_RST;
            end
            ctla_q <= GTU_CTL_RST;
            ctlb_q <= GTU_CTL_RST;
            capctl_q <= GTU_CTL_RST;
            tma_q <= GTU_VAL_RST;
            tmb_q <= GTU_VAL_RST;
            capture_reload_register_q <= GTU_VAL_RST;
            tl3_q <= 1'b0;
            tl3_p_q <= 1'b0;
            tl6_q <= 1'b0;
            tl6_p_q <= 1'b0;
            bovf_q <= 1'b0;
            pre_q <= '0;
            rdata_q <= 16'h0000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                ctl1_q[i] <= ctl1_d[i];
                tmr_q[i] <= tmr_d[i];
            end
            ctla_q <= ctla_d;
            ctlb_q <= ctlb_d;
            capctl_q <= capctl_d;
            tma_q <= tma_d;
            tmb_q <= tmb_d;
            capture_reload_register_q <= capture_reload_register_d;
            tl3_q <= tl3_d;
            tl3_p_q <= tl3_p_d;
            tl6_q <= tl6_d;
            tl6_p_q <= tl6_p_d;
            bovf_q <= bovf_d;
            pre_q <= pre_d;
            rdata_q <= rdata_d;
        end
    end

    // Outputs: latches gated by their output enables
    assign reg_rdata = rdata_q;
    assign core_toggle_output = tl3_q & ctl1_q[1][GTU_F_LATCH_CLK];
    assign second_toggle_output = tl6_q & ctlb_q[GTU_F_LATCH_CLK];
    assign timer_b_overflow = bovf_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Core wraps up from all ones
    sequence s_core_up_wrap;
        en1[1] && up1[1] && tmr_q[1] == 16'hffff && !rl_hit[0] && !rl_hit[2] && !(reg_wr && reg_addr == GTU_ADR_CORE_VAL);
    endsequence
    // Timer b wraps
    sequence s_b_wrap;
        wrap_b;
    endsequence

    AST_RESET_ZERO: assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n |=>
        (tmr_q[1] == 16'h0000 && tl3_q == 1'b0 && tl6_q == 1'b0 && !en1[1] && !en_b))
        else $error("timers not cleared by reset");
    AST_CORE_WRAP: assert property (s_core_up_wrap |=> tmr_q[1] == 16'h0000 && tl3_q != $past(tl3_q))
        else $error("core wrap wrong");
    AST_LATCH_CAUSE: assert property (tl3_q != $past(tl3_q) |-> $past(wrap1[1]))
        else $error("core latch moved without wrap");
    AST_RES1_SPACING: assert property ((en1[1] && mode1[1] == GTU_MODE_TIMER) |=>
        !(en1[1] && mode1[1] == GTU_MODE_TIMER) [*3])
        else $error("first module counts faster than four clocks");
    AST_RES2_SPACING: assert property ((en_b && ctlb_q[2:0] == 3'b000) |=> !(en_b && ctlb_q[2:0] == 3'b000))
        else $error("second module counts faster than two clocks");
    AST_GATE_BLOCK: assert property ((mode1[1] == GTU_MODE_GATED && core_count_input != ctl1_q[1][GTU_F_GATE_HI])
        |-> !en1[1])
        else $error("gated timer counted outside gate");
    AST_AUX_STOPPED: assert property (mode1[0] >= GTU_MODE_RELOAD |-> !en1[0])
        else $error("aux timer counting while capture or reload");
    AST_CAPTURE_CORE: assert property ((cap_hit[0] && !(reg_wr && reg_addr == GTU_ADR_LOWER_VAL))
        |=> tmr_q[0] == $past(tmr_q[1]))
        else $error("aux capture lost core value");
    AST_RELOAD_CORE: assert property ((rl_hit[0] && !(reg_wr && reg_addr == GTU_ADR_CORE_VAL))
        |=> tmr_q[1] == $past(tmr_q[0]))
        else $error("core reload from aux wrong");
    AST_CAPTURE_RELOAD_REGISTER: assert property ((trig2 && !(reg_wr && reg_addr == GTU_ADR_CAPREG))
        |=> capture_reload_register_q == $past(tma_q))
        else $error("capture register missed timer a");
    AST_B_WRAP: assert property (s_b_wrap |=> timer_b_overflow && tl6_q != $past(tl6_q) ##1 !timer_b_overflow)
        else $error("timer b wrap effects wrong");

    // Core value not overridden by reload or write
    logic core_free;
    assign core_free = !rl_hit[0] && !rl_hit[2] && !(reg_wr && reg_addr == GTU_ADR_CORE_VAL);

    // Sensor A rises while B low
    sequence s_quad_fwd;
        mode1[1] == GTU_MODE_INCR && ctl1_q[1][GTU_F_RUN] && rise[1] && !pin_p_q[4] && core_free;
    endsequence
    // Up count turned down by pin
    sequence s_pin_down;
        en1[1] && mode1[1] != GTU_MODE_INCR && !ctl1_q[1][GTU_F_DOWN] &&
            ctl1_q[1][GTU_F_EXTDIR] && core_direction_input && core_free;
    endsequence
    // Timer b wrap with reload on
    sequence s_b_reload;
        wrap_b && capctl_q[GTU_C_RELOAD_B] && !(reg_wr && reg_addr == GTU_ADR_B_VAL);
    endsequence
    // Latch change while timer a runs on it
    sequence s_a_tick;
        ctla_q[GTU_F_RUN] && ctla_q[GTU_F_LATCH_CLK] && ctla_q[GTU_F_MODE_LO +: 3] != GTU_MODE_COUNT &&
            tl6_chg && !trig2 && !(reg_wr && reg_addr == GTU_ADR_A_VAL);
    endsequence

    // Forward step adds one
    AST_QUAD_FWD: assert property (s_quad_fwd |=> tmr_q[1] == 16'($past(tmr_q[1]) + 16'h0001))
        else $error("forward step not counted up");
    // Pin high turns count down
    AST_DIR_PIN: assert property (s_pin_down |=> tmr_q[1] == 16'($past(tmr_q[1]) - 16'h0001))
        else $error("direction pin ignored");
    // Wrap loads capture register
    AST_B_RELOAD: assert property (s_b_reload |=> tmb_q == $past(capture_reload_register_q))
        else $error("timer b not reloaded");
    // Timer a steps on latch change
    AST_A_LATCH_CLK: assert property (s_a_tick |=> tma_q != $past(tma_q))
        else $error("timer a ignored latch clock");
    // Capture with clear empties timer a
    AST_CAP_CLEAR: assert property ((trig2 && capctl_q[GTU_C_CLEAR] && !(reg_wr && reg_addr == GTU_ADR_A_VAL))
        |=> tma_q == 16'h0000)
        else $error("timer a not cleared");
    // Core pin edge captures timer a
    AST_CAP_CORE_PIN: assert property ((capctl_q[GTU_C_CORE_IN] && core_count_input != pin_p_q[1] &&
        !(reg_wr && reg_addr == GTU_ADR_CAPREG)) |=> capture_reload_register_q == $past(tma_q))
        else $error("core pin edge missed capture");
    // Upper aux reloads core
    AST_UPPER_RELOAD: assert property ((rl_hit[2] && !rl_hit[0] && !(reg_wr && reg_addr == GTU_ADR_CORE_VAL))
        |=> tmr_q[1] == $past(tmr_q[2]))
        else $error("core reload from upper wrong");
    // Pulse only after a wrap
    AST_B_PULSE_CAUSE: assert property (timer_b_overflow |-> $past(wrap_b))
        else $error("overflow pulse without wrap");
endmodule

`default_nettype wire

/* test/gtu_quad_sensor.sv */
// Quadrature position sensor model driving the incremental inputs
`timescale 1ns/100ps
`default_nettype none
module gtu_quad_sensor (
    input wire logic sys_clk,
    input wire logic step_fwd,
    input wire logic step_rev,
    output logic sens_a,
    output logic sens_b
);
    // Gray phase of the shaft, one step per request
    logic [1:0] phase_q = 2'h0;
    // Forward steps let A lead B, reverse steps let B lead A
    always_ff @(posedge sys_clk) begin
        if (step_fwd) begin
            phase_q <= phase_q + 2'h1;
        end else if (step_rev) begin
            phase_q <= phase_q - 2'h1;
        end
    end
    // Phase to lines: 0=00 1=10 2=11 3=01, only one line moves per step
    assign sens_a = phase_q[1] ^ phase_q[0];
    assign sens_b = phase_q[1];
endmodule
`default_nettype wire

/* test/gtu_timer_unit_bench.sv */
// Self-checking bench for the dual module timer unit
`timescale 1ns/100ps
`default_nettype none
module gtu_timer_unit_bench;
    import gtu_pkg::*;
    // One counter row: timer index, preload, control, dir pin, pulses, result
    typedef struct {logic [2:0] idx; logic [15:0] pre; logic [15:0] ctl;
        logic dirv; int n; logic [15:0] exp;} gtu_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [5:0] pin = 6'h00; // Lower, core, upper, a, b, capture
    logic [4:0] dir = 5'h00; // Direction pins, bit 3 unused
    logic quad_on = 1'b0; // Core inputs fed by the sensor model
    logic step_fwd = 1'b0;
    logic step_rev = 1'b0;
    logic sens_a, sens_b, core_tl, second_tl, b_ovf;
    logic [15:0] rd_val;
    int fails = 0;
    int check_count = 0;
    int ovf_seen = 0;
    wire core_cnt = quad_on ? sens_a : pin[1];
    wire core_dir = quad_on ? sens_b : dir[1];
    gtu_row_t rows [9] = '{
        '{3'd1, 16'h0000, 16'h0842, 1'b0, 5, 16'h0005},
        '{3'd1, 16'h0000, 16'h08c2, 1'b0, 1, 16'hffff},
        '{3'd1, 16'hffff, 16'h0842, 1'b0, 1, 16'h0000},
        '{3'd1, 16'h0000, 16'h0942, 1'b1, 3, 16'hfffd},
        '{3'd0, 16'h0010, 16'h1842, 1'b0, 3, 16'h0016},
        '{3'd2, 16'h0000, 16'h1042, 1'b0, 2, 16'h0002},
        '{3'd3, 16'h0000, 16'h0842, 1'b0, 4, 16'h0004},
        '{3'd4, 16'h0000, 16'h08c2, 1'b0, 2, 16'hfffe},
        '{3'd4, 16'h0000, 16'h0942, 1'b1, 1, 16'hffff}};
    gtu_timer_unit #(.PRE_W(12)) i_gtu_timer_unit (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lower_in(pin[0]), .core_count_input(core_cnt),
        .upper_in(pin[2]), .lower_dir_in(dir[0]), .core_direction_input(core_dir),
        .upper_dir_in(dir[2]), .timer_a_in(pin[3]), .timer_b_in(pin[4]),
        .timer_b_dir_in(dir[4]), .capture_input_pin(pin[5]),
        .core_toggle_output(core_tl), .second_toggle_output(second_tl),
        .timer_b_overflow(b_ovf));
    gtu_quad_sensor i_gtu_quad_sensor (.sys_clk(sys_clk), .step_fwd(step_fwd),
        .step_rev(step_rev), .sens_a(sens_a), .sens_b(sens_b));
    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;
    // Count wrap pulses of timer b
    always @(posedge sys_clk) begin
        if (b_ovf === 1'b1) begin
            ovf_seen++;
        end
    end
    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        check_count++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data sampled in the following cycle
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        rd_val = reg_rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        check_eq(rd_val, e);
    endtask
    // Pin high two cycles, low two cycles
    task automatic pulse(input int i);
        @(posedge sys_clk);
        pin[i] <= 1'b1;
        repeat (2) @(posedge sys_clk);
        pin[i] <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // Sensor steps, forward or reverse
    task automatic step(input logic f, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            step_fwd <= f;
            step_rev <= !f;
            @(posedge sys_clk);
            step_fwd <= 1'b0;
            step_rev <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic complete_run;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        complete_run;
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 15; a++) begin
            rd_chk(4'(a), 16'h0000);
        end
        note("reset");
        // Counter rows on every timer
        for (int r = 0; r < 9; r++) begin
            wr(4'h8 + 4'(rows[r].idx), rows[r].pre);
            dir[rows[r].idx] <= rows[r].dirv;
            wr(4'(rows[r].idx), rows[r].ctl);
            repeat (rows[r].n) pulse(int'(rows[r].idx));
            wr(4'(rows[r].idx), 16'h0000);
            dir <= 5'h00;
            rd_chk(4'h8 + 4'(rows[r].idx), rows[r].exp);
        end
        rd_chk(GTU_ADR_STATUS, 16'h0001);
        note("counter");
        // Gated and plain timer runs
        wr(GTU_ADR_CORE_VAL, 16'h0000);
        wr(GTU_ADR_CORE_CTL, 16'h0241);
        repeat (40) @(posedge sys_clk);
        rd_chk(GTU_ADR_CORE_VAL, 16'h0000);
        pin[1] <= 1'b1;
        repeat (40) @(posedge sys_clk);
        wr(GTU_ADR_CORE_CTL, 16'h0000);
        pin[1] <= 1'b0;
        rd(GTU_ADR_CORE_VAL);
        check_rng(rd_val, 16'h0009, 16'h000c);
        wr(GTU_ADR_A_VAL, 16'h0000);
        wr(GTU_ADR_A_CTL, 16'h0040);
        repeat (40) @(posedge sys_clk);
        wr(GTU_ADR_A_CTL, 16'h0000);
        rd(GTU_ADR_A_VAL);
        check_rng(rd_val, 16'h0013, 16'h0017);
        note("timer");
        // Quadrature tracking
        quad_on <= 1'b1;
        wr(GTU_ADR_CORE_VAL, 16'h0000);
        wr(GTU_ADR_CORE_CTL, 16'h0043);
        step(1'b1, 4);
        rd_chk(GTU_ADR_CORE_VAL, 16'h0004);
        step(1'b0, 4);
        rd_chk(GTU_ADR_CORE_VAL, 16'h0000);
        wr(GTU_ADR_CORE_CTL, 16'h0000);
        quad_on <= 1'b0;
        note("incremental");
        // Alternating reloads from the latch
        wr(GTU_ADR_LOWER_VAL, 16'hfffe);
        wr(GTU_ADR_UPPER_VAL, 16'hfffd);
        wr(GTU_ADR_LOWER_CTL, 16'h4004);
        wr(GTU_ADR_UPPER_CTL, 16'h2004);
        wr(GTU_ADR_CORE_VAL, 16'hffff);
        wr(GTU_ADR_CORE_CTL, 16'h0c42);
        @(negedge sys_clk);
        check_eq({15'h0000, core_tl}, 16'h0001);
        pulse(1);
        rd_chk(GTU_ADR_CORE_VAL, 16'hfffe);
        check_eq({15'h0000, core_tl}, 16'h0000);
        pulse(1);
        pulse(1);
        rd_chk(GTU_ADR_CORE_VAL, 16'hfffd);
        rd_chk(GTU_ADR_LOWER_VAL, 16'hfffe);
        wr(GTU_ADR_CORE_CTL, 16'h0000);
        note("pwm");
        // Captures
        wr(GTU_ADR_CORE_VAL, 16'h1234);
        wr(GTU_ADR_UPPER_CTL, 16'h0805);
        pulse(2);
        rd_chk(GTU_ADR_UPPER_VAL, 16'h1234);
        wr(GTU_ADR_LOWER_CTL, 16'h0805);
        pulse(0);
        rd_chk(GTU_ADR_LOWER_VAL, 16'h1234);
        wr(GTU_ADR_UPPER_CTL, 16'h0804);
        wr(GTU_ADR_CORE_VAL, 16'h0000);
        pulse(2);
        rd_chk(GTU_ADR_CORE_VAL, 16'h1234);
        wr(GTU_ADR_A_VAL, 16'h0055);
        wr(GTU_ADR_CAP_CTL, 16'h0005);
        pulse(5);
        rd_chk(GTU_ADR_CAPREG, 16'h0055);
        rd_chk(GTU_ADR_A_VAL, 16'h0000);
        wr(GTU_ADR_A_VAL, 16'h0077);
        wr(GTU_ADR_CAP_CTL, 16'h0008);
        pulse(1);
        rd_chk(GTU_ADR_CAPREG, 16'h0077);
        note("capture");
        // Timer b wrap, latch and pulse
        ovf_seen = 0;
        wr(GTU_ADR_B_VAL, 16'hffff);
        wr(GTU_ADR_CAP_CTL, 16'h0020);
        wr(GTU_ADR_A_CTL, 16'h0440);
        wr(GTU_ADR_B_CTL, 16'h0c42);
        pulse(4);
        check_eq(16'(ovf_seen), 16'h0001);
        check_eq({15'h0000, second_tl}, 16'h0001);
        rd_chk(GTU_ADR_B_VAL, 16'h0077);
        rd_chk(GTU_ADR_A_VAL, 16'h0078);
        rd_chk(GTU_ADR_STATUS, 16'h0003);
        wr(GTU_ADR_STATUS, 16'h0000);
        rd_chk(GTU_ADR_STATUS, 16'h0003);
        wr(4'hf, 16'hffff);
        rd_chk(4'h7, 16'h0000);
        note("second module");
        // Reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        check_eq({14'h0000, core_tl, second_tl}, 16'h0000);
        rd_chk(GTU_ADR_STATUS, 16'h0000);
        rd_chk(GTU_ADR_B_VAL, 16'h0000);
        note("reset again");
        complete_run;
    end
endmodule
`default_nettype wire
